/* design/warning_alarm_maint_supervisor.v */
`timescale 1ns/10ps
`include "supervisor_map.vh"
module warning_alarm_maint_supervisor #(
    parameter VW = 24,
    parameter TW = 32,
    parameter MW = 32,
    parameter TICKS_PER_SEC = `SECOND_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // register port
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // measured values from the rate and temperature logic
    input wire [VW-1:0] rate_i,
    input wire [VW-1:0] temp_i,
    input wire [VW-1:0] resist_i,
    // pins and status events from outside the clock domain
    input wire on_cell_power_flag_i,
    input wire cell_low_flag_i,
    input wire flow_pulse_i,
    input wire select_key_i,
    // same-domain events
    input wire pulse_out_attempt_i,
    input wire pulse_out_overrun_i,
    input wire proc_restore_fail_i,
    input wire setup_default_i,
    input wire cal_default_i,
    input wire proc_saved_i,
    input wire setup_saved_i,
    input wire menu_entry_i,
    // outputs
    output reg [19:0] warning_word_o,
    output reg [19:0] alarm_word_o,
    output reg total_inhibit_o,
    output reg analog_sample_o,
    output reg [3:0] upper_view_o,
    output reg [3:0] lower_view_o,
    output reg [TW-1:0] total_o,
    output reg [TW-1:0] grand_total_o
);

    localparam A_CTRL = 4'h0;
    localparam A_ALARM_SEL = 4'h1;
    localparam A_LIMIT_FLOW_LO = 4'h2;
    localparam A_LIMIT_FLOW_HI = 4'h3;
    localparam A_LIMIT_TEMP_LO = 4'h4;
    localparam A_LIMIT_TEMP_HI = 4'h5;
    localparam A_LIMIT_RES_LO = 4'h6;
    localparam A_LIMIT_RES_HI = 4'h7;
    localparam A_SERVICE_TIME = 4'h8;
    localparam A_SAMPLE = 4'h9;
    localparam A_UPPER = 4'ha;
    localparam A_LOWER = 4'hb;
    localparam A_LOWER_TIME = 4'hc;
    localparam A_TOTAL = 4'hd;
    localparam A_WARN = 4'he;
    localparam A_SERVICE_CNT = 4'hf;
    localparam [31:0] TPS = TICKS_PER_SEC;

    // two-flop synchronisers for the asynchronous pins
    reg [3:0] sync_a;
    reg [3:0] sync_b;
    reg flow_prev;
    reg key_prev;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            flow_prev <= 1'b0;
            key_prev <= 1'b0;
        end else begin
            sync_a <= {select_key_i, flow_pulse_i, cell_low_flag_i,
                       on_cell_power_flag_i};
            sync_b <= sync_a;
            flow_prev <= sync_b[2];
            key_prev <= sync_b[3];
        end
    end
    wire flow_edge = sync_b[2] & ~flow_prev;
    wire key_edge = sync_b[3] & ~key_prev;

    // configuration
    reg temp_option;
    reg total_inhibit_enable;
    reg [19:0] alarm_select;
    reg [VW-1:0] flow_lo, flow_hi, temp_lo, temp_hi, res_lo, res_hi;
    reg [MW-1:0] service_interval;
    reg [MW-1:0] service_count;
    reg [9:0] analog_sample_interval;
    reg [31:0] upper_view_list;
    reg [31:0] lower_view_list;
    reg [9:0] lower_view_time;
    reg [15:0] frac_acc;
    reg [15:0] pulses_per_unit;
    reg overrun_flag, proc_def, setup_def, cal_def;

    wire wr_total = wr_i && addr_i == A_TOTAL;
    wire service_restart = wr_i && addr_i == A_CTRL && wdata_i[2];
    wire total_clear = wr_i && addr_i == A_CTRL && wdata_i[3];

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            temp_option <= 1'b0;
            total_inhibit_enable <= 1'b0;
            alarm_select <= 20'h0;
            flow_lo <= {VW{1'b0}};
            flow_hi <= {VW{1'b1}};
            temp_lo <= {VW{1'b0}};
            temp_hi <= {VW{1'b1}};
            res_lo <= {VW{1'b0}};
            res_hi <= {VW{1'b1}};
            service_interval <= {MW{1'b1}};
            analog_sample_interval <= 10'h001;
            upper_view_list <= 32'h11111132;
            lower_view_list <= 32'h11111184;
            lower_view_time <= 10'h005;
            pulses_per_unit <= 16'h0001;
        end else if (wr_i) begin
            case (addr_i)
                A_CTRL: begin
                    total_inhibit_enable <= wdata_i[0];
                    temp_option <= wdata_i[1];
                    pulses_per_unit <= (wdata_i[31:16] == 16'h0) ?
                        16'h0001 : wdata_i[31:16];
                end
                A_ALARM_SEL: alarm_select <= wdata_i[19:0] & `ALARM_MASK;
                A_LIMIT_FLOW_LO: flow_lo <= wdata_i[VW-1:0];
                A_LIMIT_FLOW_HI: flow_hi <= wdata_i[VW-1:0];
                A_LIMIT_TEMP_LO: temp_lo <= wdata_i[VW-1:0];
                A_LIMIT_TEMP_HI: temp_hi <= wdata_i[VW-1:0];
                A_LIMIT_RES_LO: res_lo <= wdata_i[VW-1:0];
                A_LIMIT_RES_HI: res_hi <= wdata_i[VW-1:0];
                A_SERVICE_TIME: service_interval <= wdata_i[MW-1:0];
                A_SAMPLE: begin
                    if (wdata_i[9:0] == 10'h0)
                        analog_sample_interval <= 10'h001;
                    else if (wdata_i[9:0] > `SAMPLE_MAX)
                        analog_sample_interval <= `SAMPLE_MAX;
                    else
                        analog_sample_interval <= wdata_i[9:0];
                end
                A_UPPER: upper_view_list <= wdata_i;
                A_LOWER: lower_view_list <= wdata_i;
                A_LOWER_TIME: lower_view_time <= (wdata_i[9:0] == 10'h0) ?
                    10'h001 : wdata_i[9:0];
                default: ;
            endcase
        end
    end

    // one second enable
    reg [31:0] sec_cnt;
    wire sec_tick = sec_cnt == TPS - 32'h1;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            sec_cnt <= 32'h0;
        else
            sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
    end

    // warning flags
    wire service_expired = service_count > service_interval;
    reg [19:0] next_warn;
    always @* begin
        next_warn = 20'h0;
        if (proc_def) next_warn = next_warn | `W_PROC_DEF;
        if (setup_def) next_warn = next_warn | `W_SETUP_DEF;
        if (cal_def) next_warn = next_warn | `W_CAL_DEF;
        if (service_expired) next_warn = next_warn | `W_SERVICE;
        if (sync_b[0]) next_warn = next_warn | `W_ON_CELL;
        if (sync_b[1]) next_warn = next_warn | `W_CELL_LOW;
        if (overrun_flag) next_warn = next_warn | `W_PULSE_OVR;
        if (rate_i < flow_lo) next_warn = next_warn | `W_FLOW_UNDER;
        if (rate_i > flow_hi) next_warn = next_warn | `W_FLOW_OVER;
        if (temp_option && temp_i < temp_lo)
            next_warn = next_warn | `W_TEMP_UNDER;
        if (temp_option && temp_i > temp_hi)
            next_warn = next_warn | `W_TEMP_OVER;
        if (temp_option && resist_i < res_lo)
            next_warn = next_warn | `W_SENS_SHORT;
        if (temp_option && resist_i > res_hi)
            next_warn = next_warn | `W_SENS_OPEN;
    end

    // sticky storage flags: set wins over clear
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            overrun_flag <= 1'b0;
            proc_def <= 1'b0;
            setup_def <= 1'b0;
            cal_def <= 1'b0;
        end else begin
            if (pulse_out_attempt_i)
                overrun_flag <= pulse_out_overrun_i;
            if (proc_restore_fail_i)
                proc_def <= 1'b1;
            else if (proc_saved_i || menu_entry_i)
                proc_def <= 1'b0;
            if (setup_default_i)
                setup_def <= 1'b1;
            else if (setup_saved_i)
                setup_def <= 1'b0;
            if (cal_default_i)
                cal_def <= 1'b1;
        end
    end

    // alarms follow warnings; only the inhibit uses them
    wire [19:0] alarm_now = next_warn & alarm_select;
    wire inhibit_now = total_inhibit_enable && (alarm_now != 20'h0);
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warning_word_o <= 20'h0;
            alarm_word_o <= 20'h0;
            total_inhibit_o <= 1'b0;
        end else begin
            warning_word_o <= next_warn | alarm_now;
            alarm_word_o <= alarm_now;
            total_inhibit_o <= inhibit_now;
        end
    end

    // maintenance timer in seconds
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            service_count <= {MW{1'b0}};
        else if (service_restart)
            service_count <= {MW{1'b0}};
        else if (sec_tick && rate_i != {VW{1'b0}} &&
                 service_count != {MW{1'b1}})
            service_count <= service_count + 1'b1;
    end

    // totals; a whole unit accrues per pulses_per_unit flow pulses
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            total_o <= {TW{1'b0}};
            grand_total_o <= {TW{1'b0}};
            frac_acc <= 16'h0;
        end else if (wr_total) begin
            total_o <= wdata_i[TW-1:0];
            frac_acc <= 16'h0;
        end else if (total_clear) begin
            total_o <= {TW{1'b0}};
        end else if (flow_edge && !inhibit_now) begin
            if (frac_acc + 16'h1 >= pulses_per_unit) begin
                frac_acc <= 16'h0;
                total_o <= total_o + 1'b1;
                grand_total_o <= grand_total_o + 1'b1;
            end else begin
                frac_acc <= frac_acc + 16'h1;
            end
        end
    end

    // analog sample pacing
    reg [9:0] sample_sec;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_sec <= 10'h0;
            analog_sample_o <= 1'b0;
        end else begin
            analog_sample_o <= 1'b0;
            if (sec_tick) begin
                if (sample_sec + 10'h1 >= analog_sample_interval) begin
                    sample_sec <= 10'h0;
                    analog_sample_o <= 1'b1;
                end else begin
                    sample_sec <= sample_sec + 10'h1;
                end
            end
        end
    end

    // display slot sequencing
    function [3:0] slot_code;
        input [31:0] list;
        input [2:0] idx;
        begin
            slot_code = list[idx*4 +: 4];
        end
    endfunction

    function is_shown;
        input [3:0] code;
        begin
            case (code)
                `SLOT_TOTAL, `SLOT_GRAND, `SLOT_RATE, `SLOT_FREQ,
                `SLOT_BATT: is_shown = 1'b1;
                `SLOT_TEMP: is_shown = 1'b1;
                default: is_shown = 1'b0;
            endcase
        end
    endfunction

    reg [2:0] up_idx, lo_idx;
    reg [9:0] lo_sec;
    wire lo_step = sec_tick && (lo_sec + 10'h1 >= lower_view_time);
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_idx <= 3'h0;
            lo_idx <= 3'h0;
            lo_sec <= 10'h0;
            upper_view_o <= `SLOT_SKIP;
            lower_view_o <= `SLOT_SKIP;
        end else begin
            if (key_edge || !is_shown(slot_code(upper_view_list, up_idx)))
                up_idx <= up_idx + 3'h1;
            if (sec_tick)
                lo_sec <= lo_step ? 10'h0 : lo_sec + 10'h1;
            if (lo_step || !is_shown(slot_code(lower_view_list, lo_idx)))
                lo_idx <= lo_idx + 3'h1;
            if (is_shown(slot_code(upper_view_list, up_idx)))
                upper_view_o <= slot_code(upper_view_list, up_idx);
            if (is_shown(slot_code(lower_view_list, lo_idx)))
                lower_view_o <= slot_code(lower_view_list, lo_idx);
        end
    end

    // register read
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rdata_o <= 32'h0;
        else if (rd_i) begin
            case (addr_i)
                A_CTRL: rdata_o <= {pulses_per_unit, 14'h0, temp_option,
                                    total_inhibit_enable};
                A_ALARM_SEL: rdata_o <= {12'h0, alarm_select};
                A_LIMIT_FLOW_LO: rdata_o <= {{(32-VW){1'b0}}, flow_lo};
                A_LIMIT_FLOW_HI: rdata_o <= {{(32-VW){1'b0}}, flow_hi};
                A_LIMIT_TEMP_LO: rdata_o <= {{(32-VW){1'b0}}, temp_lo};
                A_LIMIT_TEMP_HI: rdata_o <= {{(32-VW){1'b0}}, temp_hi};
                A_LIMIT_RES_LO: rdata_o <= {{(32-VW){1'b0}}, res_lo};
                A_LIMIT_RES_HI: rdata_o <= {{(32-VW){1'b0}}, res_hi};
                A_SERVICE_TIME: rdata_o <= service_interval;
                A_SAMPLE: rdata_o <= {22'h0, analog_sample_interval};
                A_UPPER: rdata_o <= upper_view_list;
                A_LOWER: rdata_o <= lower_view_list;
                A_LOWER_TIME: rdata_o <= {22'h0, lower_view_time};
                A_TOTAL: rdata_o <= total_o;
                A_WARN: rdata_o <= {12'h0, warning_word_o};
                A_SERVICE_CNT: rdata_o <= service_count;
                default: rdata_o <= 32'h0;
            endcase
        end else
            rdata_o <= 32'h0;
    end

endmodule // warning_alarm_maint_supervisor

/* dv/keypad_sensor_model.sv */
`timescale 1ns/10ps
module keypad_sensor_model (
    // pins toward the supervisor
    output logic flow_pulse_o,
    output logic select_key_o,
    output logic on_cell_o,
    output logic cell_low_o
);
    initial begin
        flow_pulse_o = 1'b0;
        select_key_o = 1'b0;
        on_cell_o = 1'b0;
        cell_low_o = 1'b0;
    end
    // edges several core clocks apart so the synchroniser sees each one
    task automatic flow(input int n);
        repeat (n) begin
            #23 flow_pulse_o = 1'b1;
            #23 flow_pulse_o = 1'b0;
        end
    endtask
    task automatic press;
        #41 select_key_o = 1'b1;
        #97 select_key_o = 1'b0;
    endtask
    task automatic power(input logic on, input logic low);
        #7 on_cell_o = on;
        cell_low_o = low;
    endtask
endmodule // keypad_sensor_model

/* dv/supervisor_props.sv */
`timescale 1ns/10ps
module supervisor_props #(
    parameter TW = 32
) (
    // clock, reset, register port and battery power pin
    input wire core_clk_i,
    input wire rstn_i,
    input wire [3:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire on_cell_power_flag_i,
    // status outputs
    input wire [19:0] warning_word_o,
    input wire [19:0] alarm_word_o,
    input wire total_inhibit_o,
    input wire analog_sample_o,
    input wire [3:0] upper_view_o,
    input wire [3:0] lower_view_o,
    input wire [TW-1:0] total_o,
    input wire [TW-1:0] grand_total_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // pin held past the synchroniser and the status register
    sequence cell_on_s;
        on_cell_power_flag_i [*4];
    endsequence
    sequence cell_off_s;
        !on_cell_power_flag_i [*4];
    endsequence
    sequence status_rd_s;
        rd_i && addr_i == 4'he;
    endsequence
    sequence held_inhibit_s;
        total_inhibit_o && !wr_i ##1 total_inhibit_o;
    endsequence
    alarm_follows_a: assert property (
        (alarm_word_o & ~warning_word_o) == 20'h0)
        else $error("alarm without its warning");
    inhibit_cause_a: assert property (
        total_inhibit_o |-> alarm_word_o != 20'h0)
        else $error("total inhibited with no alarm");
    inhibit_drop_a: assert property (
        held_inhibit_s |-> total_o <= $past(total_o))
        else $error("total grew while inhibited");
    storage_no_alarm_a: assert property (
        alarm_word_o[3:0] == 4'h0)
        else $error("storage warning used as alarm");
    cell_set_a: assert property (
        cell_on_s |=> warning_word_o[5])
        else $error("battery operation flag missing");
    cell_clear_a: assert property (
        cell_off_s |=> !warning_word_o[5])
        else $error("battery operation flag stuck");
    status_read_a: assert property (
        status_rd_s |=> rdata_o == {12'h0, $past(warning_word_o)})
        else $error("status read differs from warning word");
    grand_keep_a: assert property (
        grand_total_o >= $past(grand_total_o))
        else $error("grand total went down");
    sample_pulse_a: assert property (
        analog_sample_o |=> !analog_sample_o)
        else $error("sample pulse longer than one cycle");
    view_code_a: assert property (
        upper_view_o inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8} &&
        lower_view_o inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8})
        else $error("view slot code out of set");
endmodule // supervisor_props
bind warning_alarm_maint_supervisor supervisor_props #(.TW(TW)) u_props (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .on_cell_power_flag_i(on_cell_power_flag_i),
    .warning_word_o(warning_word_o), .alarm_word_o(alarm_word_o),
    .total_inhibit_o(total_inhibit_o), .analog_sample_o(analog_sample_o),
    .upper_view_o(upper_view_o), .lower_view_o(lower_view_o),
    .total_o(total_o), .grand_total_o(grand_total_o)
);

/* dv/warning_alarm_maint_supervisor_tb.sv */
`timescale 1ns/10ps
module warning_alarm_maint_supervisor_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ovr = 1'b0;
    logic [6:0] ev = 7'h0;
    logic [23:0] rate = 24'h0;
    logic [23:0] temp = 24'h0;
    logic [23:0] res = 24'h0;
    logic [31:0] v;
    wire flow, key, cell_on, cell_low, inh, smp;
    wire [31:0] rdata, tot, gtot;
    wire [19:0] warn, alarm;
    wire [3:0] up, lo;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    warning_alarm_maint_supervisor #(.TICKS_PER_SEC(10)) dut (
        .core_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rate_i(rate),
        .temp_i(temp), .resist_i(res), .on_cell_power_flag_i(cell_on),
        .cell_low_flag_i(cell_low), .flow_pulse_i(flow), .select_key_i(key),
        .pulse_out_attempt_i(ev[6]), .pulse_out_overrun_i(ovr),
        .proc_restore_fail_i(ev[0]), .setup_default_i(ev[1]),
        .cal_default_i(ev[2]), .proc_saved_i(ev[3]), .setup_saved_i(ev[4]),
        .menu_entry_i(ev[5]), .warning_word_o(warn), .alarm_word_o(alarm),
        .total_inhibit_o(inh), .analog_sample_o(smp), .upper_view_o(up),
        .lower_view_o(lo), .total_o(tot), .grand_total_o(gtot)
    );
    keypad_sensor_model pm (.flow_pulse_o(flow), .select_key_o(key),
        .on_cell_o(cell_on), .cell_low_o(cell_low));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            end_of_test;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic fire(input logic [6:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 7'h0;
        @(posedge clk);
    endtask
    task automatic ww(input logic [19:0] m, input logic [19:0] e);
        tick(6);
        check({12'h0, warn & m}, {12'h0, e});
    endtask
    task automatic wait_smp(output int n);
        n = 1;
        tick(1);
        while (smp !== 1'b1 && n < 12000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic s_reset;
        check({12'h0, warn}, 32'h0);
        check({28'h0, up}, 32'h1);
        check({28'h0, lo}, 32'h1);
        check(tot, 32'h0);
    endtask
    task automatic s_storage;
        fire(7'h01);
        ww(20'h6, 20'h2);
        fire(7'h20);
        ww(20'h6, 20'h0);
        fire(7'h02);
        ww(20'h6, 20'h4);
        fire(7'h10);
        ww(20'h6, 20'h0);
        fire(7'h04);
        fire(7'h38);
        ww(20'h9, 20'h9);
    endtask
    task automatic s_flow;
        wreg(4'h8, 32'hffff);
        wreg(4'h2, 32'h64);
        wreg(4'h3, 32'hc8);
        rate <= 24'h32;
        ww(20'hc00, 20'h400);
        rate <= 24'hfa;
        ww(20'hc00, 20'h800);
        rate <= 24'h96;
        ww(20'hc00, 20'h0);
        pm.power(1'b1, 1'b1);
        ww(20'h60, 20'h60);
        rreg(4'he, v);
        check(v, 32'h69);
        pm.power(1'b0, 1'b0);
        ww(20'h60, 20'h0);
        ovr <= 1'b1;
        fire(7'h40);
        ovr <= 1'b0;
        ww(20'h100, 20'h100);
        fire(7'h40);
        ww(20'h100, 20'h0);
    endtask
    task automatic s_inhibit;
        wreg(4'h0, 32'h1);
        wreg(4'h1, 32'hfffff);
        rate <= 24'h32;
        tick(4);
        check({12'h0, alarm}, 32'h400);
        check({31'h0, inh}, 32'h1);
        v = tot;
        pm.flow(3);
        tick(8);
        check(tot, v);
        rate <= 24'h96;
        tick(4);
        check({12'h0, alarm}, 32'h0);
        check({31'h0, inh}, 32'h0);
        wreg(4'h1, 32'h0);
        rate <= 24'h32;
        pm.flow(3);
        tick(8);
        check({31'h0, inh}, 32'h0);
        check(tot, v + 32'h3);
        v = gtot;
        wreg(4'h0, 32'h9);
        check(tot, 32'h0);
        check(gtot, v);
        wreg(4'h0, 32'h20001);
        pm.flow(1);
        tick(8);
        wreg(4'hd, 32'h5);
        pm.flow(1);
        tick(8);
        check(tot, 32'h5);
    endtask
    task automatic s_maint;
        rate <= 24'h0;
        wreg(4'h0, 32'h5);
        wreg(4'h8, 32'h2);
        tick(40);
        rreg(4'hf, v);
        check(v, 32'h0);
        rate <= 24'h96;
        tick(45);
        rreg(4'hf, v);
        check({31'h0, v > 32'h2 && v < 32'h7}, 32'h1);
        ww(20'h10, 20'h10);
        wreg(4'h1, 32'h10);
        tick(1);
        check({12'h0, alarm}, 32'h10);
        check({31'h0, inh}, 32'h1);
        rate <= 24'h0;
        wreg(4'h0, 32'h5);
        rreg(4'hf, v);
        check(v, 32'h0);
        ww(20'h10, 20'h0);
    endtask
    task automatic s_temp;
        logic [23:0] tv [3] = '{24'h5, 24'h1e, 24'hf};
        logic [19:0] we [3] = '{20'h44000, 20'h88000, 20'h0};
        wreg(4'h0, 32'h3);
        for (int a = 4; a < 8; a++)
            wreg(a[3:0], a[0] ? 32'h14 : 32'ha);
        for (int i = 0; i < 3; i++) begin
            temp <= tv[i];
            res <= tv[i];
            ww(20'hcc000, we[i]);
        end
    endtask
    task automatic s_views;
        logic [3:0] p;
        int n;
        wreg(4'hb, 32'h84848484);
        wreg(4'hc, 32'h1);
        wreg(4'ha, 32'h32323232);
        tick(25);
        p = lo;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            while (lo === p && n < 40) begin
                tick(1);
                n++;
            end
            check({28'h0, lo}, p == 4'h4 ? 32'h8 : 32'h4);
            if (i > 0)
                check(n, 10);
            p = lo;
        end
        p = up;
        tick(30);
        check({28'h0, up}, {28'h0, p});
        pm.press;
        tick(8);
        p = up;
        check({31'h0, p == 4'h2 || p == 4'h3}, 32'h1);
        pm.press;
        tick(8);
        check({28'h0, up}, p == 4'h2 ? 32'h3 : 32'h2);
    endtask
    task automatic s_sample;
        logic [31:0] sv [3] = '{32'h2, 32'h0, 32'h3e8};
        int gap [3] = '{20, 10, 9990};
        int n;
        for (int i = 0; i < 3; i++) begin
            wreg(4'h9, sv[i]);
            wait_smp(n);
            wait_smp(n);
            wait_smp(n);
            check(n, gap[i]);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        tick(4);
        rstn <= 1'b1;
        tick(1);
        s_reset;
        s_storage;
        s_flow;
        s_inhibit;
        s_maint;
        s_temp;
        s_views;
        s_sample;
        end_of_test;
    end
endmodule // warning_alarm_maint_supervisor_tb

/* pkg/supervisor_map.vh */
// What this block does
// - each alarm is active only while its own warning is active
// - inhibit option stops totalizing while any selected alarm is active
// - maintenance expired warning is code 0x00010
// - code 0x00020 on battery power, 0x00040 when battery is low
// - code 0x00100 when the last pulse output attempt overloaded
// - 0x00400 rate below low limit, 0x00800 rate above high limit
// - with temperature option: 0x04000 below low, 0x08000 above high
// - with temperature option: 0x40000 resistance below low limit, 0x80000 above high limit
// - status word is the OR of the codes of all active items
// - analog sample interval is 1 to 999 whole seconds, one sample each
// - maintenance timer counts only while rate is above zero
// - elapsed count above maintenance time raises warning, and alarm only if that alarm is selected
// - maintenance restart sets elapsed count to zero
// - total clear zeroes the resettable total, grand total untouched
// - 0x00002 set on process restore failure, cleared by a save
// - 0x00004 set while defaults used, cleared by successful save
// - 0x00009 marks calibration defaults, no user action clears it
// - the three storage warnings cannot be alarm sources
// - writing the resettable total clears the fractional accumulator
// - lower view steps per period, upper view steps per select key
// - each view has eight slots coded 1,2,3,4,5,7,8
// - a warning alone changes no operation unless its alarm is on
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH

`define W_INHIBIT     20'h00001
`define W_PROC_DEF    20'h00002
`define W_SETUP_DEF   20'h00004
`define W_CAL_DEF     20'h00009
`define W_SERVICE     20'h00010
`define W_ON_CELL     20'h00020
`define W_CELL_LOW    20'h00040
`define W_PULSE_OVR   20'h00100
`define W_FLOW_UNDER  20'h00400
`define W_FLOW_OVER   20'h00800
`define W_TEMP_UNDER  20'h04000
`define W_TEMP_OVER   20'h08000
`define W_SENS_SHORT  20'h40000
`define W_SENS_OPEN   20'h80000
`define ALARM_MASK    20'hccd70
`define SECOND_NS     1000000000
`define CLK_PERIOD_NS 5
`define SAMPLE_MAX    10'h3e7
`define SLOT_SKIP     4'h1
`define SLOT_TOTAL    4'h2
`define SLOT_GRAND    4'h3
`define SLOT_RATE     4'h4
`define SLOT_TEMP     4'h5
`define SLOT_FREQ     4'h7
`define SLOT_BATT     4'h8
`define VIEW_SLOTS    8

`endif
